/* File: inc/fsyn_pkg.sv */
// Shared constants and carriers for the feature register and phase detector
// Assumes a single core clock at 100 MHz and a serial link clock from the host
package fsyn_pkg;
   localparam int FEAT_W = 8;
   localparam int BIT_PWRDN = 3;
   localparam int BIT_CNTLOAD = 4;
   localparam int BIT_MSELOUT = 5;
   localparam int BIT_PREOUT = 6;
   localparam int BIT_DIVOFF = 7;
   localparam logic [2:0] RSVD_MASK = 3'h7;
   localparam logic [7:0] FEAT_RESET = 8'h00;

   typedef enum logic [1:0] {PD_IDLE, PD_UP, PD_DOWN} pd_state_t;

   // Two-flop synchronisers for the slow pins read by core logic
   typedef struct packed {
      logic [1:0] bus_mode;
      logic [1:0] feat_en_n;
      logic [1:0] modulus_select;
      logic [1:0] presc;
      logic [7:0] data_a;
      logic [7:0] data_b;
   } pin_sync_t;

   typedef struct packed {
      logic [7:0] shift;
      logic [7:0] feat;
      logic [2:0] ewr_sync;
      logic [2:0] ser_sync;
   } wr_state_t;

   typedef struct packed {
      logic [2:0] main_sync;
      logic [2:0] ref_sync;
      pd_state_t state;
      logic pump_up_n;
      logic pump_down_n;
      logic lock_indicator;
      logic lock_filter;
      logic diag;
      logic main_div_out;
      logic ref_div_out;
   } pd_reg_t;
endpackage : fsyn_pkg

/* File: hw/fsyn_core.sv */
// Feature control register and digital phase-frequency detector with lock indication
// Assumes divider outputs, strobes and mode pins are asynchronous to CLK_I; SCLK_I is the host serial clock
`timescale 1ns/10ps
module fsyn_core
   import fsyn_pkg::*;
(
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic SCLK_I,
   input wire logic SDATA_I,
   input wire logic FEAT_WR_I,
   input wire logic SER_WR_I,
   input wire logic SER_MODE_I,
   input wire logic BUS_MODE_I,
   input wire logic FEAT_EN_N_I,
   input wire logic [FEAT_W-1:0] DATA_I,
   input wire logic MAIN_DIV_I,
   input wire logic REF_DIV_I,
   input wire logic MODULUS_SELECT_I,
   input wire logic PRESCALER_I,
   output logic PUMP_UP_N_O,
   output logic PUMP_DOWN_N_O,
   output logic LOCK_FILTER_O,
   output logic LOCK_INDICATOR_O,
   output logic DIAG_O,
   output logic MAIN_DIV_OUT_O,
   output logic REF_DIV_OUT_O,
   output logic POWER_DOWN_O,
   output logic COUNTER_LOAD_O,
   output logic [FEAT_W-1:0] FEATURE_O
);

   // Serial link domain: shift register on the host clock
   logic [FEAT_W-1:0] shift_q;
   logic [FEAT_W-1:0] shift_d;

   always_comb begin
      shift_d = shift_q;
      if (FEAT_WR_I && !SER_WR_I) begin
         shift_d = {shift_q[FEAT_W-2:0], SDATA_I};
      end
   end

   always_ff @(posedge SCLK_I) begin
      shift_q <= shift_d;
   end

   // Core domain. Shift word is stable while the strobe is low, so it is sampled
   // a few cycles after the falling edge has been synchronised.
   pin_sync_t s_q;
   pin_sync_t s_d;
   wr_state_t w_q;
   wr_state_t w_d;
   pd_reg_t p_q;
   pd_reg_t p_d;
   logic [FEAT_W-1:0] feat_act;
   logic main_rise;
   logic ref_rise;
   logic ser_mode;

   // Pins are asynchronous to CLK_I, so nothing reads them before two flops
   always_comb begin
      s_d.bus_mode = {s_q.bus_mode[0], BUS_MODE_I};
      s_d.feat_en_n = {s_q.feat_en_n[0], FEAT_EN_N_I};
      s_d.modulus_select = {s_q.modulus_select[0], MODULUS_SELECT_I};
      s_d.presc = {s_q.presc[0], PRESCALER_I};
      s_d.data_a = DATA_I;
      s_d.data_b = s_q.data_a;
   end

   always_ff @(posedge CLK_I) begin
      s_q <= s_d;
   end

   always_comb begin
      w_d = w_q;
      w_d.ewr_sync = {w_q.ewr_sync[1:0], FEAT_WR_I};
      w_d.ser_sync = {w_q.ser_sync[1:0], SER_MODE_I};
      w_d.shift = shift_q;
      ser_mode = w_q.ser_sync[1];
      if (!s_q.bus_mode[1]) begin
         if (ser_mode && w_q.ewr_sync[2] && !w_q.ewr_sync[1]) begin
            w_d.feat = w_q.shift;
         end else if (!ser_mode && !w_q.ewr_sync[2] && w_q.ewr_sync[1]) begin
            w_d.feat = s_q.data_b;
         end
      end
      if (SRST_I) begin
         w_d.feat = FEAT_RESET;
      end
   end

   always_ff @(posedge CLK_I) begin
      w_q <= w_d;
   end

   // Reserved bits are ignored; the whole register is gated by the enable pin
   assign feat_act = s_q.feat_en_n[1] ? FEAT_RESET : (w_q.feat & ~{5'h00, RSVD_MASK});
   assign main_rise = p_q.main_sync[1] && !p_q.main_sync[2];
   assign ref_rise = p_q.ref_sync[1] && !p_q.ref_sync[2];

   always_comb begin
      p_d = p_q;
      p_d.main_sync = {p_q.main_sync[1:0], MAIN_DIV_I};
      p_d.ref_sync = {p_q.ref_sync[1:0], REF_DIV_I};
      case (p_q.state)
         PD_IDLE: begin
            if (main_rise && !ref_rise) begin
               p_d.state = PD_DOWN;
            end else if (ref_rise && !main_rise) begin
               p_d.state = PD_UP;
            end
         end
         PD_UP: begin
            if (main_rise) begin
               p_d.state = PD_IDLE;
            end
         end
         PD_DOWN: begin
            if (ref_rise) begin
               p_d.state = PD_IDLE;
            end
         end
         default: p_d.state = PD_IDLE;
      endcase
      // Power down freezes the detector in its idle state
      if (feat_act[BIT_PWRDN]) begin
         p_d.state = PD_IDLE;
      end
      // Pulse lasts from leading edge to lagging edge
      p_d.pump_up_n = !(p_d.state == PD_UP);
      p_d.pump_down_n = !(p_d.state == PD_DOWN);
      p_d.lock_filter = !(p_d.pump_up_n && p_d.pump_down_n);
      p_d.lock_indicator = p_d.pump_up_n && p_d.pump_down_n;
      if (feat_act[BIT_MSELOUT]) begin
         p_d.diag = s_q.modulus_select[1];
      end else if (feat_act[BIT_PREOUT]) begin
         p_d.diag = s_q.presc[1];
      end else begin
         p_d.diag = 1'b0;
      end
      p_d.main_div_out = !feat_act[BIT_DIVOFF] && !feat_act[BIT_PWRDN] && p_q.main_sync[1];
      p_d.ref_div_out = !feat_act[BIT_DIVOFF] && !feat_act[BIT_PWRDN] && p_q.ref_sync[1];
      if (SRST_I) begin
         p_d.state = PD_IDLE;
         p_d.pump_up_n = 1'b1;
         p_d.pump_down_n = 1'b1;
         p_d.lock_filter = 1'b0;
         p_d.lock_indicator = 1'b1;
         p_d.diag = 1'b0;
         p_d.main_div_out = 1'b0;
         p_d.ref_div_out = 1'b0;
      end
   end

   always_ff @(posedge CLK_I) begin
      p_q <= p_d;
   end

   assign PUMP_UP_N_O = p_q.pump_up_n;
   assign PUMP_DOWN_N_O = p_q.pump_down_n;
   assign LOCK_FILTER_O = p_q.lock_filter;
   assign LOCK_INDICATOR_O = p_q.lock_indicator;
   assign DIAG_O = p_q.diag;
   assign MAIN_DIV_OUT_O = p_q.main_div_out;
   assign REF_DIV_OUT_O = p_q.ref_div_out;
   assign POWER_DOWN_O = feat_act[BIT_PWRDN];
   assign COUNTER_LOAD_O = feat_act[BIT_CNTLOAD];
   assign FEATURE_O = w_q.feat;

endmodule : fsyn_core

/* File: bench/fsyn_host.sv */
// Host model for the feature write port, serial and parallel
// Assumes calls start just after a core clock edge; link clock runs only in frames
`timescale 1ns/10ps
module fsyn_host (
   output logic sclk_o,
   output logic sdata_o,
   output logic wr_o,
   output logic [7:0] data_o
);
   initial {sclk_o, sdata_o, wr_o, data_o} = 11'h0;
   task automatic wr(input logic ser, input logic [7:0] v);
      v[2:0] = 3'h0;
      if (ser) begin
         wr_o = 1'h1;
         for (int i = 7; i >= 0; i--) begin
            sdata_o = v[i];
            #15 sclk_o = 1'h1;
            #15 sclk_o = 1'h0;
         end
         sdata_o = ~sdata_o;
         #30 wr_o = 1'h0;
      end else begin
         data_o = v;
         #30 wr_o = 1'h1;
         #60 data_o = ~v;
         #30 wr_o = 1'h0;
      end
   endtask : wr
endmodule : fsyn_host

/* File: bench/fsyn_core_chk.sv */
// Port checker for fsyn_core
// Assumes it is bound to the core and sees its ports only
`timescale 1ns/10ps
module fsyn_core_chk
   import fsyn_pkg::*;
(
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic FEAT_EN_N_I,
   input wire logic MAIN_DIV_I,
   input wire logic REF_DIV_I,
   input wire logic MODULUS_SELECT_I,
   input wire logic PUMP_UP_N_O,
   input wire logic PUMP_DOWN_N_O,
   input wire logic LOCK_FILTER_O,
   input wire logic LOCK_INDICATOR_O,
   input wire logic DIAG_O,
   input wire logic MAIN_DIV_OUT_O,
   input wire logic POWER_DOWN_O,
   input wire logic [FEAT_W-1:0] FEATURE_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   wire logic idle = PUMP_UP_N_O & PUMP_DOWN_N_O;
   // Other input held low so no lagging edge can cut the pulse short
   sequence s_main;
      $rose(MAIN_DIV_I) && !REF_DIV_I && idle && !POWER_DOWN_O ##1 (!REF_DIV_I && !POWER_DOWN_O) [*3];
   endsequence
   sequence s_ref;
      $rose(REF_DIV_I) && !MAIN_DIV_I && idle && !POWER_DOWN_O ##1 (!MAIN_DIV_I && !POWER_DOWN_O) [*3];
   endsequence
   a_down_pulse: assert property (s_main |-> ##[0:2] !PUMP_DOWN_N_O) else $error("no down");
   a_up_pulse: assert property (s_ref |-> ##[0:2] !PUMP_UP_N_O) else $error("no up");
   a_pumps_apart: assert property (PUMP_UP_N_O || PUMP_DOWN_N_O) else $error("both low");
   a_lock_and: assert property (LOCK_INDICATOR_O == idle) else $error("lock");
   a_filter_nand: assert property (!$past(SRST_I) |-> LOCK_FILTER_O != idle) else $error("filter");
   // Enable pin passes two synchroniser flops before it gates the register
   a_power_down: assert property (POWER_DOWN_O == (FEATURE_O[BIT_PWRDN] && !$past(FEAT_EN_N_I, 2)))
      else $error("pwr");
   a_diag_modulus_select: assert property ((FEATURE_O[BIT_MSELOUT] && !FEAT_EN_N_I && MODULUS_SELECT_I) [*4] |-> DIAG_O)
      else $error("diag");
   a_div_off: assert property ((FEATURE_O[BIT_DIVOFF] && !FEAT_EN_N_I) [*4] |-> !MAIN_DIV_OUT_O) else $error("div");
endmodule : fsyn_core_chk

/* File: bench/fsyn_core_test.sv */
// Bench for fsyn_core: feature rows, refusal, enable, pumps, reset
// Assumes fsyn_host drives the write port
`timescale 1ns/10ps
module fsyn_core_test;
   import fsyn_pkg::*;
   logic CLK_I = 0, SRST_I = 1, SER_WR_I = 0, SER_MODE_I = 0, BUS_MODE_I = 0, FEAT_EN_N_I = 0;
   logic MAIN_DIV_I = 0, REF_DIV_I = 0, MODULUS_SELECT_I = 0, PRESCALER_I = 0, SCLK_I, SDATA_I, FEAT_WR_I;
   logic PUMP_UP_N_O, PUMP_DOWN_N_O, LOCK_FILTER_O, LOCK_INDICATOR_O, DIAG_O, MAIN_DIV_OUT_O, REF_DIV_OUT_O;
   logic POWER_DOWN_O, COUNTER_LOAD_O;
   logic [7:0] DATA_I, FEATURE_O;
   int err_count = 0, total_checks = 0;
   // Value, then {serial, modulus_select, prescaler} and {power, load, diag, dividers on}
   logic [14:0] rows[6] = '{{8'h18, 7'h5C}, {8'h40, 7'h13}, {8'h60, 7'h51}, {8'h20, 7'h23}, {8'h87, 7'h70},
      {8'h00, 7'h31}};
   always #5 CLK_I = ~CLK_I;
   fsyn_host host (.sclk_o(SCLK_I), .sdata_o(SDATA_I), .wr_o(FEAT_WR_I), .data_o(DATA_I));
   fsyn_core dut (.*);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      if (err_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim
   task automatic pd(input logic lm, input int g, input logic [7:0] eu, input logic [7:0] ed);
      int nu = 0;
      int nd = 0;
      if (lm) MAIN_DIV_I = ~MAIN_DIV_I;
      else REF_DIV_I = ~REF_DIV_I;
      for (int i = 0; i < 20; i++) begin
         if (i == g) begin
            if (lm) REF_DIV_I = ~REF_DIV_I;
            else MAIN_DIV_I = ~MAIN_DIV_I;
         end
         @(posedge CLK_I);
         #1 nu += !PUMP_UP_N_O;
         nd += !PUMP_DOWN_N_O;
      end
      chk(16'(nu), 16'(eu));
      chk(16'(nd), 16'(ed));
   endtask : pd
   initial begin
      #20000 err_count++;
      end_sim();
   end
   initial begin
      repeat (6) @(posedge CLK_I);
      #1 SRST_I = 0;
      {MAIN_DIV_I, REF_DIV_I} = 2'h3;
      foreach (rows[i]) begin
         {SER_MODE_I, MODULUS_SELECT_I, PRESCALER_I} = rows[i][6:4];
         host.wr(rows[i][6], rows[i][14:7]);
         repeat (8) @(posedge CLK_I);
         #1 chk(16'(FEATURE_O), 16'(rows[i][14:7] & 8'hF8));
         chk(16'({POWER_DOWN_O, COUNTER_LOAD_O, DIAG_O, MAIN_DIV_OUT_O, REF_DIV_OUT_O}),
            16'({rows[i][3:0], rows[i][0]}));
      end
      BUS_MODE_I = 1;
      host.wr(0, 8'h08);
      repeat (8) @(posedge CLK_I);
      #1 chk(16'(FEATURE_O), 16'h0000);
      BUS_MODE_I = 0;
      host.wr(0, 8'h98);
      FEAT_EN_N_I = 1;
      repeat (8) @(posedge CLK_I);
      #1 chk(16'({FEATURE_O, POWER_DOWN_O, MAIN_DIV_OUT_O}), 16'h0261);
      {MAIN_DIV_I, REF_DIV_I} = 2'h0;
      repeat (6) @(posedge CLK_I);
      #1 pd(1, 4, 8'h00, 8'h04);
      pd(0, 6, 8'h00, 8'h00);
      pd(0, 9, 8'h09, 8'h00);
      pd(1, 2, 8'h00, 8'h00);
      pd(1, 0, 8'h00, 8'h00);
      SRST_I = 1;
      repeat (2) @(posedge CLK_I);
      #1 chk(16'({FEATURE_O, PUMP_UP_N_O, PUMP_DOWN_N_O, LOCK_FILTER_O}), 16'h0006);
      end_sim();
   end
endmodule : fsyn_core_test
bind fsyn_core fsyn_core_chk chk (.*);
